// *** dma_ctrl_pkg.sv ***
package dma_ctrl_pkg;

    localparam int ADDR_WIDTH = 12;
    localparam int DATA_WIDTH = 32;
    localparam int CHANNELS = 4;

    // register map: byte address of each word
    localparam logic [ADDR_WIDTH-1:0] DMA_MODULE_CONTROL_ADDR = 12'h000;

    // field positions inside dma_module_control
    localparam int ENABLE_POS = 15;
    localparam int SUSPEND_POS = 12;
    localparam int ACTIVE_POS = 11;

    // reset values of the control and status bits
    localparam logic ENABLE_RESET = 1'h0;
    localparam logic SUSPEND_RESET = 1'h0;
    localparam logic ACTIVE_RESET = 1'h0;
    localparam logic [DATA_WIDTH-1:0] READ_ZERO = 32'h0000_0000;

    // ahb-lite encodings
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    typedef struct packed {
        logic enable;
        logic suspend;
    } ctrl_type;

    typedef struct packed {
        logic sel;
        logic write;
        logic [ADDR_WIDTH-1:0] addr;
    } bus_phase_type;

    typedef enum logic [2:0] {
        ENG_IDLE = 3'b001,
        ENG_XFER = 3'b010,
        ENG_HOLD = 3'b100
    } engine_state_type;

endpackage : dma_ctrl_pkg

// *** dma_rr_arbiter.sv ***
module dma_rr_arbiter
    import dma_ctrl_pkg::*;
#(
    parameter int N = CHANNELS
) (
    input wire logic [N-1:0] request,
    input wire logic [N-1:0] lastGrant,
    output logic [N-1:0] pick
);

    logic [$clog2(N)-1:0] startIdx;
    logic found;
    int idx;

    // search starts one above the last winner so no channel starves
    always_comb begin
        startIdx = '0;
        for (int i = 0; i < N; i++) begin
            if (lastGrant[i]) begin
                startIdx = $clog2(N)'(i + 1);
            end
        end
    end

    always_comb begin
        pick = '0;
        found = 1'b0;
        idx = 0;
        for (int k = 0; k < N; k++) begin
            idx = (int'(startIdx) + k) % N;
            if (!found && request[idx]) begin
                pick[idx] = 1'b1;
                found = 1'b1;
            end
        end
    end

endmodule : dma_rr_arbiter

// *** dma_global_control.sv ***
// Overview of operation
// - control word is 32 bits; all bits except enable/suspend/busy read zero
// - enable bit 15 set lets channel transfers proceed
// - enable bit 15 clear stops all channel grants; busy stays up while engineActive drains
// - suspend bit 12 set stops new transfers, freeing the data bus for the CPU
// - suspend bit 12 clear resumes normal transfers
// - busy bit 11 reads one while the module is actively operating
// - busy bit 11 reads zero when disabled and moving no data
module dma_global_control
    import dma_ctrl_pkg::*;
#(
    parameter int N = CHANNELS
) (
    input wire logic clk_sys,
    input wire logic rstn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [ADDR_WIDTH-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [DATA_WIDTH-1:0] hwdata,
    input wire logic hready,
    output logic [DATA_WIDTH-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // channel side of the engine
    input wire logic [N-1:0] chanReq,
    input wire logic xferDone,
    input wire logic engineActive,
    output logic [N-1:0] chanGrant,
    output ctrl_type ctrlOut,
    output logic suspendAck,
    output logic activeFlag
);

    // ---------------------------------------------------------------
    // shared decode
    // ---------------------------------------------------------------
    function automatic logic hitsControl(input logic [ADDR_WIDTH-1:0] a);
        hitsControl = (a[ADDR_WIDTH-1:2] == DMA_MODULE_CONTROL_ADDR[ADDR_WIDTH-1:2]);
    endfunction : hitsControl

    function automatic logic [DATA_WIDTH-1:0] packControl(input ctrl_type c, input logic act);
        logic [DATA_WIDTH-1:0] w;
        w = READ_ZERO;
        w[ENABLE_POS] = c.enable;
        w[SUSPEND_POS] = c.suspend;
        w[ACTIVE_POS] = act;
        packControl = w;
    endfunction : packControl

    // ---------------------------------------------------------------
    // bus slave: address phase capture and response
    // ---------------------------------------------------------------
    bus_phase_type phase_r;
    bus_phase_type phase_nxt;
    logic [DATA_WIDTH-1:0] hrdata_r;
    logic [DATA_WIDTH-1:0] hrdata_nxt;
    logic hreadyout_r;
    logic hreadyout_nxt;
    logic hresp_r;
    logic hresp_nxt;
    logic addrPhaseValid;
    logic writeStrobe;

    // control and status registers
    ctrl_type ctrl_r;
    ctrl_type ctrl_nxt;
    logic activeFlag_r;
    logic activeFlag_nxt;

    // engine sequencing
    engine_state_type state_r;
    engine_state_type state_nxt;
    logic [N-1:0] chanGrant_r;
    logic [N-1:0] chanGrant_nxt;
    logic [N-1:0] lastGrant_r;
    logic [N-1:0] lastGrant_nxt;
    logic suspendAck_r;
    logic suspendAck_nxt;
    logic [N-1:0] pick;
    logic mayStart;

    assign addrPhaseValid = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign writeStrobe = phase_r.sel && phase_r.write && hitsControl(phase_r.addr);

    always_comb begin
        phase_nxt = phase_r;
        hreadyout_nxt = 1'b1;
        hresp_nxt = HRESP_OKAY;
        hrdata_nxt = hrdata_r;
        if (hready) begin
            phase_nxt.sel = addrPhaseValid;
            phase_nxt.write = hwrite;
            phase_nxt.addr = haddr;
        end
        // read data built from next values so a read right behind a
        // write sees the written bits with no wait state
        if (addrPhaseValid && !hwrite) begin
            if (hitsControl(haddr)) begin
                hrdata_nxt = packControl(ctrl_nxt, activeFlag_nxt);
            end else begin
                hrdata_nxt = READ_ZERO;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            phase_r <= '0;
            hrdata_r <= READ_ZERO;
            hreadyout_r <= 1'b1;
            hresp_r <= HRESP_OKAY;
        end else begin
            phase_r <= phase_nxt;
            hrdata_r <= hrdata_nxt;
            hreadyout_r <= hreadyout_nxt;
            hresp_r <= hresp_nxt;
        end
    end

    // ---------------------------------------------------------------
    // control register
    // ---------------------------------------------------------------
    always_comb begin
        ctrl_nxt = ctrl_r;
        // only two bits take write data, the rest are dropped
        if (writeStrobe) begin
            ctrl_nxt.enable = hwdata[ENABLE_POS];
            ctrl_nxt.suspend = hwdata[SUSPEND_POS];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ctrl_r.enable <= ENABLE_RESET;
            ctrl_r.suspend <= SUSPEND_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // ---------------------------------------------------------------
    // channel arbitration and transfer sequencing
    // ---------------------------------------------------------------
    dma_rr_arbiter #(
        .N(N)
    ) arbiter (
        .request(chanReq),
        .lastGrant(lastGrant_r),
        .pick(pick)
    );

    // uses the registered bits: a new setting acts from the next edge
    assign mayStart = ctrl_r.enable && !ctrl_r.suspend && (chanReq != '0);

    always_comb begin
        state_nxt = state_r;
        chanGrant_nxt = chanGrant_r;
        lastGrant_nxt = lastGrant_r;
        case (state_r)
            ENG_IDLE: begin
                chanGrant_nxt = '0;
                if (mayStart) begin
                    chanGrant_nxt = pick;
                    lastGrant_nxt = pick;
                    state_nxt = ENG_XFER;
                end else if (ctrl_r.enable && ctrl_r.suspend) begin
                    state_nxt = ENG_HOLD;
                end
            end
            ENG_XFER: begin
                if (!ctrl_r.enable) begin
                    // disabling aborts at once; the beat in flight is dropped
                    chanGrant_nxt = '0;
                    state_nxt = ENG_IDLE;
                end else if (xferDone) begin
                    // suspend waits for the beat boundary to keep the bus legal
                    chanGrant_nxt = '0;
                    state_nxt = ctrl_r.suspend ? ENG_HOLD : ENG_IDLE;
                end
            end
            ENG_HOLD: begin
                chanGrant_nxt = '0;
                // resume grants at once, so leaving suspend costs no extra cycle
                if (mayStart) begin
                    chanGrant_nxt = pick;
                    lastGrant_nxt = pick;
                    state_nxt = ENG_XFER;
                end else if (!ctrl_r.enable || !ctrl_r.suspend) begin
                    state_nxt = ENG_IDLE;
                end
            end
            default: begin
                chanGrant_nxt = '0;
                state_nxt = ENG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_r <= ENG_IDLE;
            chanGrant_r <= '0;
            lastGrant_r <= '0;
        end else begin
            state_r <= state_nxt;
            chanGrant_r <= chanGrant_nxt;
            lastGrant_r <= lastGrant_nxt;
        end
    end

    // ---------------------------------------------------------------
    // status
    // ---------------------------------------------------------------
    always_comb begin
        // engineActive keeps the flag up while a disabled engine drains
        activeFlag_nxt = (state_nxt == ENG_XFER) || engineActive;
        suspendAck_nxt = (state_nxt == ENG_HOLD);
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            activeFlag_r <= ACTIVE_RESET;
            suspendAck_r <= 1'b0;
        end else begin
            activeFlag_r <= activeFlag_nxt;
            suspendAck_r <= suspendAck_nxt;
        end
    end

    // ---------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ---------------------------------------------------------------
    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign chanGrant = chanGrant_r;
    assign ctrlOut = ctrl_r;
    assign suspendAck = suspendAck_r;
    assign activeFlag = activeFlag_r;

endmodule : dma_global_control

// *** dma_global_control_props.sv ***
module dma_global_control_props
    import dma_ctrl_pkg::*;
#(
    parameter int N = CHANNELS
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [ADDR_WIDTH-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [DATA_WIDTH-1:0] hrdata,
    input wire logic [N-1:0] chanReq,
    input wire logic xferDone,
    input wire logic engineActive,
    input wire logic [N-1:0] chanGrant,
    input wire ctrl_type ctrlOut,
    input wire logic activeFlag
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_grant_onehot: assert property ($onehot0(chanGrant))
        else $error("grant not one-hot");
    a_off_no_grant: assert property (!ctrlOut.enable |=> !(|chanGrant))
        else $error("grant while disabled");
    a_suspend_hold: assert property (ctrlOut.suspend && !(|chanGrant) |=> !(|chanGrant))
        else $error("grant while suspended");
    a_grant_start: assert property (ctrlOut.enable && !ctrlOut.suspend && !(|chanGrant)
        && !$past(|chanGrant) && |chanReq |=> |chanGrant) else $error("request not granted");
    a_grant_end: assert property (|chanGrant && xferDone |=> !(|chanGrant))
        else $error("grant outlived its beat");
    a_busy_grant: assert property (|chanGrant |-> activeFlag)
        else $error("busy low during grant");
    a_busy_engine: assert property (engineActive |=> activeFlag)
        else $error("busy low while engine active");
    a_idle_clear: assert property (!ctrlOut.enable && !engineActive |=> !activeFlag)
        else $error("busy high while idle");
    a_zero_bits: assert property (hrdata[31:16] == 16'h0 && hrdata[14:13] == 2'h0 && hrdata[10:0] == 11'h0)
        else $error("unimplemented bit set");
    a_read_ctrl: assert property (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && haddr[11:2] == 10'h0
        |=> hrdata[15] == ctrlOut.enable && hrdata[12] == ctrlOut.suspend) else $error("read word wrong");
endmodule : dma_global_control_props

// *** dma_global_control_bench.sv ***
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin mismatches++; \
    $display("BAD %s expected %h seen %h", n, e, s); end end
module dma_global_control_bench import dma_ctrl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'h0, rstn = 1'h0, hsel = 1'h0, hwrite = 1'h0, xferDone = 1'h0, engineActive = 1'h0;
    logic [ADDR_WIDTH-1:0] haddr = 12'h0;
    logic [1:0] htrans = HTRANS_IDLE;
    logic [2:0] hsize = 3'h2;
    logic [DATA_WIDTH-1:0] hwdata = 32'h0, hrdata, rd;
    logic [3:0] chanReq = 4'h0, chanGrant;
    logic hready, hreadyout, hresp, activeFlag, suspendAck;
    ctrl_type ctrlOut;
    int mismatches = 0, cmp_count = 0;
    // single slave, so its ready is the bus ready
    assign hready = hreadyout;
    always #50 clk_sys = ~clk_sys;
    dma_global_control #(.N(4)) DUT (.clk_sys, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .chanReq, .xferDone, .engineActive, .chanGrant, .ctrlOut,
        .suspendAck, .activeFlag);
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        do @(posedge clk_sys); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= HTRANS_IDLE;
        hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'h1);
        rd = hrdata;
    endtask : bus
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        `CHK("word", e, rd)
    endtask : rdchk
    task automatic t_reset;
        `CHK("ctrl", 2'h0, ctrlOut)
        `CHK("busy", 1'h0, activeFlag)
        `CHK("grant", 4'h0, chanGrant)
        `CHK("suspack", 1'h0, suspendAck)
        `CHK("ready", 1'h1, hreadyout)
        `CHK("resp", HRESP_OKAY, hresp)
        rdchk(12'h000, 32'h0);
    endtask : t_reset
    task automatic t_regs;
        bus(1'h1, 12'h000, 32'hFFFF_FFFF);
        rdchk(12'h000, 32'h0000_9000);
        bus(1'h1, 12'h004, 32'hFFFF_FFFF);
        rdchk(12'h004, 32'h0);
        bus(1'h1, 12'h000, 32'h0);
        tick(1);
        rdchk(12'h000, 32'h0);
    endtask : t_regs
    task automatic t_grant;
        bus(1'h1, 12'h000, 32'h0000_8000);
        chanReq <= 4'h3;
        tick(2);
        `CHK("grant", 4'h1, chanGrant)
        `CHK("busy", 1'h1, activeFlag)
        xferDone <= 1'h1;
        tick(1);
        xferDone <= 1'h0;
        tick(1);
        `CHK("gap", 4'h0, chanGrant)
        tick(1);
        `CHK("next", 4'h2, chanGrant)
        rdchk(12'h000, 32'h0000_8800);
        bus(1'h1, 12'h000, 32'h0);
        tick(1);
        rdchk(12'h000, 32'h0);
        `CHK("abort", 4'h0, chanGrant)
    endtask : t_grant
    task automatic t_suspend;
        chanReq <= 4'h8;
        bus(1'h1, 12'h000, 32'h0000_9000);
        tick(4);
        `CHK("held", 4'h0, chanGrant)
        `CHK("suspack", 1'h1, suspendAck)
        bus(1'h1, 12'h000, 32'h0000_8000);
        tick(2);
        `CHK("resume", 4'h8, chanGrant)
        `CHK("unsusp", 1'h0, suspendAck)
        xferDone <= 1'h1;
        chanReq <= 4'h0;
        tick(1);
        xferDone <= 1'h0;
        bus(1'h1, 12'h000, 32'h0);
        tick(1);
    endtask : t_suspend
    task automatic t_engine;
        engineActive <= 1'h1;
        tick(2);
        `CHK("busy", 1'h1, activeFlag)
        rdchk(12'h000, 32'h0000_0800);
        engineActive <= 1'h0;
        tick(2);
        `CHK("idle", 1'h0, activeFlag)
    endtask : t_engine
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    initial begin
        tick(2);
        rstn <= 1'h1;
        tick(1);
        t_reset();
        t_regs();
        t_grant();
        t_suspend();
        t_engine();
        finish_test();
    end
    // whole run is about 50 cycles; generous margin before giving up
    initial begin
        tick(2000);
        mismatches++;
        finish_test();
    end
endmodule : dma_global_control_bench
bind dma_global_control dma_global_control_props #(.N(N)) props (.clk_sys, .rstn, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hrdata, .chanReq, .xferDone, .engineActive, .chanGrant, .ctrlOut, .activeFlag);
